// [qdc_pkg.sv]
// Constants and types shared by the quad converter serial command unit
// =====================================================================
// Notes on behaviour
// RL1 - Frames are 24 bits MSB first: command nibble, address nibble, data word.
// RL2 - Serial input shifts in on each serial clock fall while frame select low.
// RL3 - Address nibble is one-hot per channel; any channel combination allowed.
// RL4 - Mask bit set makes a channel ignore the load strobe entirely.
// RL5 - Command 0011 writes and updates addressed channels regardless of strobe.
// RL6 - Command 1000 loads the chain mode setting.
// RL7 - Chain bit 0 low is standalone (reset default), high is daisy-chain.
// RL8 - In chain mode extra clocks shift older bits out on serial output.
// RL9 - Serial output changes on clock rise, valid at following fall.
// RL10 - Host gives exactly 24 clocks per chained device.
// RL11 - Frame ending off a multiple of 24 still executes as valid.
// RL12 - Frame select rise latches the shift register and stops shifting.
// RL13 - Continuous clock needs exact select timing; gated clock needs exact burst.
// RL14 - Command 1001 reads back; one address bit picks channel, data ignored.
// RL15 - Serial output enabled for a readback transfer, then disabled again.
// RL16 - Readback with zero or several address bits returns channel A.
// RL17 - Next frame shifts four undefined bits then the DAC register contents.
// RL18 - Host collects readback with an all-zero or chain no-op frame.
// RL19 - Command 0100 loads power word, two bits per channel, D highest.
// RL20 - Power code 00 is normal; other codes power the channel down.
// RL21 - Codes 01, 10, 11 select 1k, 100k ground or three-state.
// RL22 - Powered-down output leaves amplifier and goes to termination.
// RL23 - Power-down keeps DAC register and still accepts its updates.
// RL24 - Each channel has input register and DAC register, strobe governed.
// RL25 - Strobe low during 0001 updates input and DAC at select rise.
// RL26 - Strobe high: 0001 only loads input; strobe fall copies to DAC.
// =====================================================================
package qdc_pkg;
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int NUM_CHAN = 4;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int PWR_MSB = 7;
  localparam int MASK_MSB = 3;
  localparam int CHAIN_BIT = 0;
  // Command codes
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PWR = 4'h4;
  localparam logic [3:0] CMD_MASK = 4'h5;
  localparam logic [3:0] CMD_CHAIN = 4'h8;
  localparam logic [3:0] CMD_READ = 4'h9;
  localparam logic [3:0] CMD_NOP_CHAIN = 4'hF;
  // Readback padding around the 16-bit code
  localparam logic [3:0] RB_HEAD = 4'h0;
  localparam logic [3:0] RB_TAIL = 4'h0;
  // Reset values
  localparam logic [23:0] SHIFT_RST = 24'h00_0000;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0] PMODE_RST = 2'h0;
  localparam logic MASK_RST = 1'b0;
  localparam logic CHAIN_RST = 1'b0;
  // Power mode codes
  localparam logic [1:0] PM_NORMAL = 2'h0;
  typedef logic [15:0] qdc_word_t;
  typedef logic [3:0][15:0] qdc_bank_t;
  typedef logic [23:0] qdc_frame_t;
endpackage

// [qdc_serial_cmd.sv]
// Serial command unit of a four-channel converter: shift, decode, registers
`timescale 1ns/1ps
module qdc_serial_cmd
  import qdc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic frame_sel_n,
  input wire logic serial_in,
  input wire logic load_strobe_n,
  output logic serial_out,
  output logic serial_out_en,
  output qdc_pkg::qdc_bank_t dac_code,
  output logic [3:0] power_mode_hi,
  output logic [3:0] power_mode_lo,
  output logic [3:0] amp_connect,
  output logic chain_mode_enable
);
  import qdc_pkg::*;

  // =================================================================
  // Input synchronisers
  // Every pin crosses two flops; the third stage only feeds edge finders
  logic sclk_s1, sclk_s2, sclk_s3;
  logic fsel_s1, fsel_s2, fsel_s3;
  logic sin_s1, sin_s2;
  logic ls_s1, ls_s2, ls_s3;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      fsel_s1 <= 1'b1;
      fsel_s2 <= 1'b1;
      fsel_s3 <= 1'b1;
      sin_s1 <= 1'b0;
      sin_s2 <= 1'b0;
      ls_s1 <= 1'b1;
      ls_s2 <= 1'b1;
      ls_s3 <= 1'b1;
    end
    else
    begin
      sclk_s1 <= serial_clk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      fsel_s1 <= frame_sel_n;
      fsel_s2 <= fsel_s1;
      fsel_s3 <= fsel_s2;
      sin_s1 <= serial_in;
      sin_s2 <= sin_s1;
      ls_s1 <= load_strobe_n;
      ls_s2 <= ls_s1;
      ls_s3 <= ls_s2;
    end
  end

  // Edge pulses, one clk cycle each
  logic sclk_fall, sclk_rise, frame_rise, frame_fall, ls_fall;
  assign sclk_fall = sclk_s3 & ~sclk_s2;
  assign sclk_rise = ~sclk_s3 & sclk_s2;
  assign frame_rise = ~fsel_s3 & fsel_s2;
  assign frame_fall = fsel_s3 & ~fsel_s2;
  assign ls_fall = ls_s3 & ~ls_s2;

  // =================================================================
  // Shift register and frame fields
  qdc_frame_t shreg_r;
  logic [3:0] cmd_w, addr_w;
  qdc_word_t data_w;
  qdc_word_t dac_r [NUM_CHAN];
  qdc_word_t inp_r [NUM_CHAN];
  qdc_word_t rb_word;
  logic [1:0] rb_sel;
  logic exec_read;

  // Fields read MSB first from the captured frame
  // RL1 - frame field layout
  assign cmd_w = shreg_r[CMD_MSB:CMD_LSB];
  assign addr_w = shreg_r[ADDR_MSB:ADDR_LSB];
  assign data_w = shreg_r[DATA_MSB:0];
  // RL11 - any length executes
  // RL14 - readback command decode
  assign exec_read = frame_rise && (cmd_w == CMD_READ);

  // Readback channel pick; anything but one-hot falls back to channel A
  // RL16 - default to channel A
  always_comb
  begin
    case (addr_w)
      4'h2: rb_sel = 2'h1;
      4'h4: rb_sel = 2'h2;
      4'h8: rb_sel = 2'h3;
      default: rb_sel = 2'h0;
    endcase
    rb_word = dac_r[rb_sel];
  end

  // Shifting stops while select is high, so the command reads a still frame
  // RL2 - sample on falls
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shreg_r <= SHIFT_RST;
    // RL17 - preload readback word
    else if (exec_read)
      shreg_r <= {RB_HEAD, rb_word, RB_TAIL};
    // RL12 - frozen while select high
    else if (sclk_fall && !fsel_s2)
      shreg_r <= {shreg_r[FRAME_BITS-2:0], sin_s2};
  end

  // =================================================================
  // Serial output path
  // Presenting on the rise gives the far end a half period of setup
  logic so_r, rb_active_r, chain_r;

  // RL9 - change on rise
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      so_r <= 1'b0;
    // RL8 - older bits ripple out
    else if (frame_fall || (sclk_rise && !fsel_s2))
      so_r <= shreg_r[FRAME_BITS-1];
  end

  // Readback window lasts from the read command to the end of the next frame
  // RL15 - temporary output enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rb_active_r <= 1'b0;
    else if (exec_read)
      rb_active_r <= 1'b1;
    else if (frame_rise)
      rb_active_r <= 1'b0;
  end

  // Chain mode setting
  // RL6 - chain command
  // RL7 - standalone by default
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      chain_r <= CHAIN_RST;
    else if (frame_rise && (cmd_w == CMD_CHAIN))
      chain_r <= shreg_r[CHAIN_BIT];
  end

  assign serial_out = so_r;
  assign serial_out_en = chain_r | rb_active_r;
  assign chain_mode_enable = chain_r;

  // =================================================================
  // Per-channel registers
  // Unpacked so that each channel's process owns its own element
  logic mask_r [NUM_CHAN];
  logic [1:0] pmode_r [NUM_CHAN];
  logic amp_r [NUM_CHAN];

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      logic sel;
      logic wr_in, upd_now, strobe_copy;
      // RL3 - one-hot channel select
      assign sel = addr_w[g];
      assign wr_in = frame_rise && sel && ((cmd_w == CMD_WR_IN) || (cmd_w == CMD_WR_UPD));
      // RL4 - mask blocks strobe
      assign strobe_copy = ls_fall && !mask_r[g];

      // Input register; written by 0001 and 0011
      // RL24 - double buffer
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          inp_r[g] <= CODE_RST;
        else if (wr_in)
          inp_r[g] <= data_w;
      end

      // DAC register; frame commands win over a coincident strobe fall
      // RL23 - updates regardless of power
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          dac_r[g] <= CODE_RST;
        // RL5 - immediate update
        else if (frame_rise && sel && (cmd_w == CMD_WR_UPD))
          dac_r[g] <= data_w;
        // RL25 - transparent with strobe low
        else if (frame_rise && sel && (cmd_w == CMD_WR_IN) && !ls_s2 && !mask_r[g])
          dac_r[g] <= data_w;
        else if (frame_rise && sel && (cmd_w == CMD_UPD))
          dac_r[g] <= inp_r[g];
        // RL26 - deferred copy on strobe fall
        else if (strobe_copy)
          dac_r[g] <= inp_r[g];
      end

      // Load strobe mask bit
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          mask_r[g] <= MASK_RST;
        else if (frame_rise && (cmd_w == CMD_MASK))
          mask_r[g] <= shreg_r[g];
      end

      // Power mode pair and amplifier switch
      // RL19 - two bits per channel
      // RL20 - 00 normal
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          pmode_r[g] <= PMODE_RST;
          // Amplifier state follows the power code it resets to
          amp_r[g] <= (PMODE_RST == PM_NORMAL);
        end
        else if (frame_rise && (cmd_w == CMD_PWR))
        begin
          pmode_r[g] <= shreg_r[2*g+1 -: 2];
          amp_r[g] <= (shreg_r[2*g+1 -: 2] == PM_NORMAL);
        end
      end

      // Code 01 = 1k, 10 = 100k, 11 = open; decoded by the analog stage
      // RL21 - termination code
      // RL22 - amplifier disconnect
      assign power_mode_hi[g] = pmode_r[g][1];
      assign power_mode_lo[g] = pmode_r[g][0];
      assign amp_connect[g] = amp_r[g];
      assign dac_code[g] = dac_r[g];

      // Deferred copy lands one cycle after the strobe fall
      // A coincident frame command wins, so those cycles are left out
      // RL26 - strobe copy check
      a_strobe_copy: assert property (@(posedge clk) disable iff (sys_rst) // RL26
        (ls_fall && !mask_r[g] && !frame_rise) |=> (dac_r[g] == $past(inp_r[g])))
        else $error("strobe fall did not copy input to dac");
      // RL4 - masked channel holds
      a_mask_holds: assert property (@(posedge clk) disable iff (sys_rst) // RL4
        (ls_fall && mask_r[g] && !frame_rise) |=> $stable(dac_r[g]))
        else $error("masked channel followed the strobe");
      // RL5 - immediate update check
      a_write_update: assert property (@(posedge clk) disable iff (sys_rst) // RL5
        (frame_rise && addr_w[g] && cmd_w == CMD_WR_UPD) |=>
        (dac_r[g] == $past(data_w)) && (inp_r[g] == $past(data_w)))
        else $error("write and update missed a channel");
      // RL20 - amplifier follows power code
      a_amp_follow: assert property (@(posedge clk) disable iff (sys_rst) // RL20
        amp_r[g] == (pmode_r[g] == PM_NORMAL))
        else $error("amplifier switch disagrees with power code");
      // Strobe high at execute: only the input side moves
      // RL26 - deferred write holds
      a_defer_hold: assert property (@(posedge clk) disable iff (sys_rst) // RL26
        (frame_rise && addr_w[g] && cmd_w == CMD_WR_IN && ls_s2) |=>
        $stable(dac_r[g]) && (inp_r[g] == $past(data_w)))
        else $error("deferred write reached the dac register");
      // RL25 - transparent write check
      a_transparent: assert property (@(posedge clk) disable iff (sys_rst) // RL25
        (frame_rise && addr_w[g] && cmd_w == CMD_WR_IN && !ls_s2 && !mask_r[g]) |=>
        (dac_r[g] == $past(data_w)))
        else $error("strobe low write did not reach the dac register");
      // RL24 - update command check
      a_update_copy: assert property (@(posedge clk) disable iff (sys_rst) // RL24
        (frame_rise && addr_w[g] && cmd_w == CMD_UPD) |=> (dac_r[g] == $past(inp_r[g])))
        else $error("update command did not copy input to dac");
      // A power word must never disturb the stored code
      // RL23 - code kept in power-down
      a_pd_keeps: assert property (@(posedge clk) disable iff (sys_rst) // RL23
        (frame_rise && cmd_w == CMD_PWR && !ls_fall) |=> $stable(dac_r[g]))
        else $error("power word changed a dac register");
    end
  endgenerate

  // =================================================================
  // Checks on the serial path
  sequence s_read_cmd;
    frame_rise && (cmd_w == CMD_READ);
  endsequence

  sequence s_shift_tick;
    sclk_fall && !fsel_s2;
  endsequence

  // Window closes at the first frame end that carries no new read
  sequence s_window_close;
    rb_active_r && frame_rise && !exec_read;
  endsequence

  // RL2 - shift check
  a_shift_fall: assert property (@(posedge clk) disable iff (sys_rst) // RL2
    s_shift_tick |=> (shreg_r == {$past(shreg_r[FRAME_BITS-2:0]), $past(sin_s2)}))
    else $error("shift register did not take serial input");
  // RL12 - freeze check
  a_frame_freeze: assert property (@(posedge clk) disable iff (sys_rst) // RL12
    (fsel_s2 && !frame_rise) |=> $stable(shreg_r))
    else $error("shift register moved while select high");
  // RL9 - output on rise
  a_out_on_rise: assert property (@(posedge clk) disable iff (sys_rst) // RL9
    (sclk_rise && !fsel_s2) |=> (serial_out == $past(shreg_r[FRAME_BITS-1])))
    else $error("serial output not updated on clock rise");
  // RL15 - enable across readback
  a_rb_enable: assert property (@(posedge clk) disable iff (sys_rst) // RL15
    s_read_cmd |=> serial_out_en ##1 (serial_out_en throughout (!frame_rise)[*2]))
    else $error("readback did not enable serial output");
  // Fallback read must still carry channel A's code
  // RL16 - fallback channel check
  a_rb_default: assert property (@(posedge clk) disable iff (sys_rst) // RL16
    (s_read_cmd and ($countones(addr_w) != 1)) |=>
    (shreg_r[ADDR_MSB:4] == $past(dac_r[0])))
    else $error("readback did not default to channel A");
  // RL7 - chain setting check
  a_chain_load: assert property (@(posedge clk) disable iff (sys_rst) // RL7
    (frame_rise && cmd_w == CMD_CHAIN) |=> (chain_mode_enable == $past(shreg_r[CHAIN_BIT])))
    else $error("chain setting not loaded");
  // RL19 - power word layout
  a_power_word: assert property (@(posedge clk) disable iff (sys_rst) // RL19
    (frame_rise && cmd_w == CMD_PWR) |=>
    ({power_mode_hi[3], power_mode_lo[3], power_mode_hi[0], power_mode_lo[0]} ==
     {$past(shreg_r[7:6]), $past(shreg_r[1:0])}))
    else $error("power word placed on wrong channels");
  // RL15 - window closes again
  a_rb_close: assert property (@(posedge clk) disable iff (sys_rst) // RL15
    s_window_close |=> !rb_active_r)
    else $error("readback window stayed open");
  // RL17 - readback word placement
  a_rb_load: assert property (@(posedge clk) disable iff (sys_rst) // RL17
    s_read_cmd |=> (shreg_r == {RB_HEAD, $past(rb_word), RB_TAIL}))
    else $error("readback word not placed in the shift register");
  // First bit shows as soon as select falls, before any clock rise
  // RL8 - first output bit
  a_first_bit: assert property (@(posedge clk) disable iff (sys_rst) // RL8
    frame_fall |=> (serial_out == $past(shreg_r[FRAME_BITS-1])))
    else $error("first bit not presented at frame start");
endmodule

// [qdc_host.sv]
// Host-side serial link model that sends frames and captures reply bits
`timescale 1ns/1ps
module qdc_host
(
  input wire logic clk,
  output logic serial_clk,
  output logic frame_sel_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [47:0] reply;
  // ==========================================================
  // Idle levels: clock parked low, frame deselected
  initial
  begin
    serial_clk = 1'b0;
    frame_sel_n = 1'b1;
    serial_in = 1'b0;
    reply = '0;
  end
  // Step to just after a system clock rise
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [47:0] word, input int nbits);
    int i;
    frame_sel_n = 1'b0;
    tick(8);
    for (i = nbits - 1; i >= 0; i--)
    begin
      serial_clk = 1'b1;
      serial_in = word[i];
      tick(4);
      // take the bit presented at the rise, as the clock falls
      reply[i] = serial_out;
      serial_clk = 1'b0;
      tick(4);
    end
    frame_sel_n = 1'b1;
    // Released data line must not keep its last value
    serial_in = ~serial_in;
    tick(8);
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the quad converter serial command unit
`timescale 1ns/1ps
module testbench;
  import qdc_pkg::*;
  logic clk;
  logic sys_rst;
  logic load_strobe_n;
  logic serial_clk;
  logic frame_sel_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_en;
  wire sdo_pin;
  qdc_bank_t dac_code;
  logic [3:0] power_mode_hi;
  logic [3:0] power_mode_lo;
  logic [3:0] amp_connect;
  logic chain_mode_enable;
  int failures;
  int samples_checked;
  // ==========================================================
  // Pin floats when released, so the host never reads stale data
  assign sdo_pin = serial_out_en ? serial_out : 1'bz;
  // 40 MHz system clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  qdc_serial_cmd u_qdc_serial_cmd (
    .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .frame_sel_n(frame_sel_n), .serial_in(serial_in),
    .load_strobe_n(load_strobe_n), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .dac_code(dac_code),
    .power_mode_hi(power_mode_hi), .power_mode_lo(power_mode_lo),
    .amp_connect(amp_connect), .chain_mode_enable(chain_mode_enable)
  );
  qdc_host u_qdc_host (
    .clk(clk), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
    .serial_in(serial_in), .serial_out(sdo_pin)
  );
  // ==========================================================
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [23:0] w);
    u_qdc_host.send({24'h00_0000, w}, 24);
  endtask
  task automatic t_reset();
    chk("chain", 24'h00_0000, 24'(chain_mode_enable));
    chk("out_en", 24'h00_0000, 24'(serial_out_en));
    chk("amp", 24'h00_000F, 24'(amp_connect));
    chk("dac", 24'h00_0000, 24'(dac_code[0]));
    $display("test reset done");
  endtask
  // Per-channel writes, then one two-channel write
  task automatic t_write();
    int ch;
    for (ch = 0; ch < 4; ch++)
      frame({CMD_WR_UPD, 4'(1 << ch), 16'(16'h1111 * (ch + 1))});
    frame({CMD_WR_UPD, 4'hA, 16'hBEEF});
    for (ch = 0; ch < 4; ch++)
      chk("dac", 24'(ch[0] ? 16'hBEEF : 16'(16'h1111 * (ch + 1))), 24'(dac_code[ch]));
    $display("test write done");
  endtask
  // Every single select, then none and two selects fall back to A
  task automatic t_readback();
    logic [3:0] adr [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h3};
    logic [15:0] want [6] = '{16'h1111, 16'hBEEF, 16'h3333, 16'hBEEF, 16'h1111, 16'h1111};
    int k;
    for (k = 0; k < 6; k++)
    begin
      frame({CMD_READ, adr[k], 16'hFFFF});
      chk("rb_en", 24'h00_0001, 24'(serial_out_en));
      frame(24'h00_0000);
      chk("rb_word", 24'(want[k]), 24'(u_qdc_host.reply[19:4]));
      chk("rb_off", 24'h00_0000, 24'(serial_out_en));
    end
    $display("test readback done");
  endtask
  // Two-device frame: first word must ripple out after 24 clocks
  task automatic t_chain();
    frame(24'h80_0001);
    chk("chain_on", 24'h00_0001, 24'(chain_mode_enable));
    // Own word is a NOP; the write to channel A must only pass through
    u_qdc_host.send({24'h31_0005, 24'hF0_0000}, 48);
    chk("ripple_old", 24'h80_0001, u_qdc_host.reply[47:24]);
    chk("ripple", 24'h31_0005, u_qdc_host.reply[23:0]);
    chk("dac_kept", 24'h00_1111, 24'(dac_code[0]));
    frame(24'h80_0000);
    chk("chain_off", 24'h00_0000, 24'(serial_out_en));
    $display("test chain done");
  endtask
  // Frame of 16 clocks executes the last 24 bits held
  task automatic t_short();
    frame(24'h00_0031);
    u_qdc_host.send(48'h0000_0000_CDEF, 16);
    chk("short", 24'h00_CDEF, 24'(dac_code[0]));
    $display("test short done");
  endtask
  task automatic t_power();
    frame({CMD_PWR, 4'h0, 16'h00E4});
    chk("pm_hi", 24'h00_000C, 24'(power_mode_hi));
    chk("pm_lo", 24'h00_000A, 24'(power_mode_lo));
    chk("amp_pd", 24'h00_0001, 24'(amp_connect));
    frame({CMD_WR_UPD, 4'h2, 16'h7777});
    chk("pd_dac", 24'h00_7777, 24'(dac_code[1]));
    frame({CMD_PWR, 4'h0, 16'h0000});
    chk("amp_up", 24'h00_000F, 24'(amp_connect));
    $display("test power done");
  endtask
  // Deferred load, mask, transparent load and explicit update
  task automatic t_strobe();
    frame({CMD_MASK, 4'h0, 16'h0002});
    frame({CMD_WR_IN, 4'hF, 16'h1234});
    chk("held", 24'h00_3333, 24'(dac_code[2]));
    load_strobe_n = 1'b0;
    tick(8);
    chk("ld_a", 24'h00_1234, 24'(dac_code[0]));
    chk("ld_b", 24'h00_7777, 24'(dac_code[1]));
    frame({CMD_WR_IN, 4'h1, 16'h5555});
    chk("transp", 24'h00_5555, 24'(dac_code[0]));
    load_strobe_n = 1'b1;
    frame({CMD_UPD, 4'h2, 16'h0000});
    chk("upd_b", 24'h00_1234, 24'(dac_code[1]));
    frame({CMD_MASK, 4'h0, 16'h0000});
    $display("test strobe done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard well beyond the expected run length
  initial
  begin
    #2_000_000;
    failures++;
    complete_run();
  end
  initial
  begin
    failures = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    load_strobe_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    tick(4);
    t_reset();
    t_write();
    t_readback();
    t_chain();
    t_short();
    t_power();
    t_strobe();
    complete_run();
  end
endmodule
